// >>> hdl/frame_restart_sync.sv
// scan address counters with frame restart handling
//
// Contract
// R1: restart falling edge halts counters and drives address outputs low
// R2: restart rising edge loads outputs from start address register pair
// R3: after release counters advance on the next character clock edge
// R4: asynchronous release may shorten the first address period
// R5: outside logic retimes restart edges to the character clock edge
// R6: outside logic issues one restart pulse per mains cycle
// R7: adjust register appends extra non-displayed scan lines each frame
// R8: host makes frame slightly longer than the restart period
// R9: without restart, host tunes frame time within a few percent of mains
//
// scan scheme
// - each clock is one character slot; the address steps once a slot
// - every raster line of a row starts again at the row base address
// - at a row change the address carries on past the last character
// - adjust lines follow the last row and repeat its base address
// - restart low clears both outputs and holds every counter at zero
// - the first clock with restart high loads the start address pair
// - the clock after that counts again, so a release costs no slot
// - restart is taken as retimed outside; a pin that moves between
//   clock edges only shifts the release to the next clock, so the
//   first address after release always lasts one whole clock
`include "frame_restart_sync_params.svh"
`timescale 1ns/100ps
module frame_restart_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // frame restart, active low, already retimed outside
  input wire logic frame_restart_n_i,
  // format settings
  input wire logic [`FMT_WIDTH-1:0] horiz_total_i,
  input wire logic [`FMT_WIDTH-1:0] vert_total_i,
  input wire logic [`RA_WIDTH-1:0] row_lines_i,
  input wire logic [`RA_WIDTH-1:0] vert_adjust_i,
  input wire logic [`SAH_WIDTH-1:0] start_address_high_i,
  input wire logic [7:0] start_address_low_i,
  // scan outputs
  output logic [`MA_WIDTH-1:0] memory_address_out_o,
  output logic [`RA_WIDTH-1:0] raster_row_out_o,
  output logic frame_end_o,
  output logic adjust_active_o
);
  //--------------------------------------------------
  // restart edges
  //--------------------------------------------------
  logic fall;
  logic rise;
  logic low;
  restart_edge_detect u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .restart_n_i(frame_restart_n_i),
    .fall_o(fall),
    .rise_o(rise),
    .low_o(low)
  );

  //--------------------------------------------------
  // scan state
  //--------------------------------------------------
  frame_restart_sync_pkg::scan_state_t state_r;
  logic [`FMT_WIDTH-1:0] hcnt_r;
  logic [`FMT_WIDTH-1:0] vcnt_r;
  logic [`RA_WIDTH-1:0] adj_r;
  logic [`MA_WIDTH-1:0] row_base_r;
  logic [`MA_WIDTH-1:0] start_addr;
  logic line_end;
  logic row_end;
  logic frame_last;
  logic in_adjust;
  logic adj_last;
  logic frame_done;

  assign start_addr = {start_address_high_i, start_address_low_i}; // R2
  assign line_end = (hcnt_r == horiz_total_i);
  assign row_end = line_end && (raster_row_out_o == row_lines_i);
  assign frame_last = row_end && (vcnt_r == vert_total_i);
  // adjust lines are whole lines counted after the last row
  assign in_adjust = (state_r == frame_restart_sync_pkg::SCAN_ADJUST);
  assign adj_last = in_adjust && (adj_r == vert_adjust_i - 5'h01);
  // last character slot of a frame, with or without adjust lines
  assign frame_done = line_end && (adj_last ||
    (state_r == frame_restart_sync_pkg::SCAN_RUN && frame_last &&
     vert_adjust_i == `ADJ_RESET));

  //--------------------------------------------------
  // scan sequence
  //--------------------------------------------------
  // rows, then adjust lines, halted while restart low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= frame_restart_sync_pkg::SCAN_RUN;
    end else if (ce_i) begin
      if (fall || low) begin
        state_r <= frame_restart_sync_pkg::SCAN_HALT; // R1
      end else begin
        unique case (state_r)
          frame_restart_sync_pkg::SCAN_HALT: begin
            // release clock: scanning resumes from the start pair
            state_r <= frame_restart_sync_pkg::SCAN_RUN; // R3
          end
          frame_restart_sync_pkg::SCAN_RUN: begin
            // after the last row, go on with adjust lines if any
            if (frame_last && vert_adjust_i != `ADJ_RESET) begin
              state_r <= frame_restart_sync_pkg::SCAN_ADJUST; // R7
            end
          end
          frame_restart_sync_pkg::SCAN_ADJUST: begin
            if (line_end && adj_r == vert_adjust_i - 5'h01) begin
              state_r <= frame_restart_sync_pkg::SCAN_RUN;
            end
          end
        endcase
      end
    end
  end

  //--------------------------------------------------
  // character and row counters
  //--------------------------------------------------
  // character slot within the line, row within the frame, adjust line
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hcnt_r <= `HTOT_RESET;
      vcnt_r <= `VTOT_RESET;
      adj_r <= `ADJ_RESET;
    end else if (ce_i) begin
      // restart low or its release starts every count afresh
      if (low || rise) begin
        hcnt_r <= `HTOT_RESET; // R1
        vcnt_r <= `VTOT_RESET;
        adj_r <= `ADJ_RESET;
      end else if (line_end) begin
        hcnt_r <= `HTOT_RESET;
        if (state_r == frame_restart_sync_pkg::SCAN_ADJUST) begin
          // one more adjust line done; wrap after the last one
          adj_r <= adj_r + 5'h01; // R7
          if (adj_r == vert_adjust_i - 5'h01) begin
            vcnt_r <= `VTOT_RESET;
            adj_r <= `ADJ_RESET;
          end
        end else if (row_end) begin
          vcnt_r <= frame_last ? `VTOT_RESET : vcnt_r + 8'h01;
        end
      end else begin
        // next character slot of the line
        hcnt_r <= hcnt_r + 8'h01; // R3
      end
    end
  end

  //--------------------------------------------------
  // memory address and raster row outputs
  //--------------------------------------------------
  // address steps per character; lines of a row repeat the row base
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      memory_address_out_o <= `MA_RESET;
      raster_row_out_o <= `RA_RESET;
      row_base_r <= `MA_RESET;
    end else if (ce_i) begin
      // restart low: hold everything at zero
      if (low) begin
        memory_address_out_o <= `MA_RESET; // R1
        raster_row_out_o <= `RA_RESET; // R1
        row_base_r <= `MA_RESET;
      end else if (rise) begin // R4
        // release: first address is the start pair for one whole clock
        memory_address_out_o <= start_addr; // R2
        raster_row_out_o <= `RA_RESET;
        row_base_r <= start_addr;
      end else if (line_end) begin
        // restart line at row base, or step to next row
        if (state_r == frame_restart_sync_pkg::SCAN_ADJUST) begin
          // adjust line: same base, next line, start pair after the last
          raster_row_out_o <= raster_row_out_o + 5'h01;
          memory_address_out_o <= row_base_r;
          if (adj_r == vert_adjust_i - 5'h01) begin
            memory_address_out_o <= start_addr;
            row_base_r <= start_addr;
            raster_row_out_o <= `RA_RESET;
          end
        end else if (frame_last && vert_adjust_i == `ADJ_RESET) begin
          // frame over with no adjust lines: back to the start pair
          memory_address_out_o <= start_addr;
          row_base_r <= start_addr;
          raster_row_out_o <= `RA_RESET;
        end else if (frame_last) begin
          // frame over: adjust lines repeat the last row base
          memory_address_out_o <= row_base_r;
          raster_row_out_o <= `RA_RESET;
        end else if (row_end) begin
          // next row carries on after the last character
          memory_address_out_o <= memory_address_out_o + 14'h0001;
          row_base_r <= memory_address_out_o + 14'h0001;
          raster_row_out_o <= `RA_RESET;
        end else begin
          // next raster line of the same row
          memory_address_out_o <= row_base_r;
          raster_row_out_o <= raster_row_out_o + 5'h01;
        end
      end else begin
        // inside a line: next character
        memory_address_out_o <= memory_address_out_o + 14'h0001; // R3
      end
    end
  end

  //--------------------------------------------------
  // frame status flags
  //--------------------------------------------------
  // a restart cuts the frame short, so no end pulse is given for it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_end_o <= 1'b0;
      adjust_active_o <= 1'b0;
    end else if (ce_i) begin
      frame_end_o <= ~low && ~rise && frame_done; // R8
      adjust_active_o <= in_adjust; // R7
    end
  end
endmodule : frame_restart_sync

// >>> hdl/restart_edge_detect.sv
// restart input edge detector
`timescale 1ns/100ps
module restart_edge_detect (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // restart level
  input wire logic restart_n_i,
  // edge pulses and restart low level
  output logic fall_o,
  output logic rise_o,
  output logic low_o
);
  logic prev_r;

  // previous level, idle high
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= 1'b1;
    end else if (ce_i) begin
      prev_r <= restart_n_i;
    end
  end

  // combinational edges so the counters act in the same cycle
  assign fall_o = prev_r & ~restart_n_i;
  assign rise_o = ~prev_r & restart_n_i;
  assign low_o = ~restart_n_i;
endmodule : restart_edge_detect

// >>> inc/frame_restart_sync_params.svh
// constants for the frame restart and scan counter block
`ifndef FRAME_RESTART_SYNC_PARAMS_SVH
`define FRAME_RESTART_SYNC_PARAMS_SVH
`define MA_WIDTH 14
`define RA_WIDTH 5
`define FMT_WIDTH 8
`define SAH_WIDTH 6
`define MA_RESET 14'h0000
`define RA_RESET 5'h00
`define ADJ_RESET 5'h00
`define HTOT_RESET 8'h00
`define VTOT_RESET 8'h00
`define ROWS_RESET 5'h00
`define CLK_PERIOD_NS 20
`endif

// >>> inc/frame_restart_sync_pkg.sv
// types for the frame restart and scan counter block
package frame_restart_sync_pkg;
  typedef enum logic [1:0] {
    SCAN_RUN,
    SCAN_ADJUST,
    SCAN_HALT
  } scan_state_t;
endpackage : frame_restart_sync_pkg

// >>> testbench/frame_restart_sync_monitor.sv
// concurrent checks on the restart block ports
`include "frame_restart_sync_params.svh"
`timescale 1ns/100ps
module frame_restart_sync_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // watched inputs
  input wire logic frame_restart_n_i,
  input wire logic [`FMT_WIDTH-1:0] horiz_total_i,
  input wire logic [`RA_WIDTH-1:0] vert_adjust_i,
  input wire logic [`SAH_WIDTH-1:0] start_address_high_i,
  input wire logic [7:0] start_address_low_i,
  // watched outputs
  input wire logic [`MA_WIDTH-1:0] memory_address_out_o,
  input wire logic [`RA_WIDTH-1:0] raster_row_out_o,
  input wire logic adjust_active_o
);
  wire logic [`MA_WIDTH-1:0] start_w = {start_address_high_i,
    start_address_low_i};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_low_clears: assert property (
    ce_i && !frame_restart_n_i |=>
    memory_address_out_o == '0 && raster_row_out_o == '0)
    else $error("outputs not cleared under restart");
  a_rise_loads: assert property (
    ce_i && frame_restart_n_i && !$past(frame_restart_n_i) |=>
    memory_address_out_o == $past(start_w) && raster_row_out_o == '0)
    else $error("start address not loaded");
  a_counts_on: assert property (
    ce_i && $rose(frame_restart_n_i) ##1
    ce_i && frame_restart_n_i && horiz_total_i != '0 |=>
    memory_address_out_o == $past(memory_address_out_o) + 14'h0001)
    else $error("no count after release");
  a_first_whole: assert property (
    ce_i && $rose(frame_restart_n_i) |->
    memory_address_out_o == '0 ##1 memory_address_out_o == $past(start_w))
    else $error("first address cut short");
  a_adjust_needs: assert property (
    $rose(adjust_active_o) |->
    vert_adjust_i != '0 || $past(vert_adjust_i) != '0)
    else $error("adjust lines without setting");
endmodule : frame_restart_sync_monitor
bind frame_restart_sync frame_restart_sync_monitor u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .frame_restart_n_i(frame_restart_n_i), .horiz_total_i(horiz_total_i),
  .vert_adjust_i(vert_adjust_i),
  .start_address_high_i(start_address_high_i),
  .start_address_low_i(start_address_low_i),
  .memory_address_out_o(memory_address_out_o),
  .raster_row_out_o(raster_row_out_o), .adjust_active_o(adjust_active_o));

// >>> testbench/mains_restart_gen.sv
// retimed mains restart pulse source for the scan counters
`timescale 1ns/100ps
module mains_restart_gen #(
  parameter int PERIOD = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pulse control
  input wire logic en_i,
  input wire logic [3:0] width_i,
  // restart towards the controller, active low
  output logic frame_restart_n_o
);
  int cnt_r;
  // one low pulse per mains period, moved only at the clock edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 0;
      frame_restart_n_o <= 1'b1;
    end else begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      frame_restart_n_o <= !(en_i && cnt_r < int'(width_i));
    end
  end
endmodule : mains_restart_gen

// >>> testbench/testbench.sv
// self-checking bench for the scan counter restart block
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
  mismatches++; $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module testbench;
  logic clk_i = 0, rst_i = 1, ce_i = 1, en = 0, fe, aa, restart_n;
  logic [3:0] wid = 4'h1;
  logic [7:0] h = 8'h03, v = 8'h01, sal = 8'h00;
  logic [4:0] rows = 5'h01, adj = 5'h02, ra;
  logic [5:0] sah = 6'h00;
  logic [13:0] ma, hold, st0 = 14'h0000, st1 = 14'h0000;
  logic [2:0] hist = 3'h7;
  int mismatches = 0, n_tests = 0, n, na;
  initial forever #10 clk_i = ~clk_i;
  mains_restart_gen #(.PERIOD(20)) u_src (.clk_i(clk_i), .rst_i(rst_i),
    .en_i(en), .width_i(wid), .frame_restart_n_o(restart_n));
  frame_restart_sync u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .frame_restart_n_i(restart_n), .horiz_total_i(h), .vert_total_i(v),
    .row_lines_i(rows), .vert_adjust_i(adj), .start_address_high_i(sah),
    .start_address_low_i(sal), .memory_address_out_o(ma),
    .raster_row_out_o(ra), .frame_end_o(fe), .adjust_active_o(aa));
  task automatic tally_and_finish;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // cycles from one frame end pulse to the next, bounded;
  // na counts the cycles with adjust lines flagged in that frame
  task automatic frame_len(output int len);
    len = 0;
    @(negedge clk_i);
    while (fe !== 1'b1 && len < 200) begin
      @(negedge clk_i);
      len++;
    end
    if (len < 200) len = 0;
    na = 0;
    do begin
      @(negedge clk_i);
      len++;
      na += (aa === 1'b1);
    end while (fe !== 1'b1 && len < 200);
    if (len >= 200) begin
      mismatches++;
      tally_and_finish;
    end
  endtask : frame_len
  // model: outputs follow restart levels and start pair of recent edges
  always @(negedge clk_i) begin
    if (rst_i) hist = 3'h7;
    else begin
      if (hist[0] === 1'b0) begin
        `CHK("ma_low", 14'h0000, ma)
        `CHK("ra_low", 5'h00, ra)
      end else if (hist[1] === 1'b0) begin
        `CHK("ma_start", st0, ma)
        `CHK("ra_start", 5'h00, ra)
      end else if (hist[2] === 1'b0 && h != 0)
        `CHK("ma_next", st1 + 14'h0001, ma)
      hist = {hist[1:0], restart_n};
      st1 = st0;
      st0 = {sah, sal};
    end
  end
  // free running frames first, then restart once per mains period
  initial begin
    n = $urandom(54);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    frame_len(n);
    frame_len(n);
    `CHK("frame_adj", 24, n)
    `CHK("adj_cycles", 8, na)
    @(posedge clk_i) adj <= 5'h00;
    frame_len(n);
    frame_len(n);
    `CHK("frame_plain", 16, n)
    `CHK("adj_none", 0, na)
    // clock enable low freezes the scan
    @(posedge clk_i) ce_i <= 1'b0;
    @(negedge clk_i) hold = ma;
    repeat (3) @(negedge clk_i);
    `CHK("ma_frozen", hold, ma)
    @(posedge clk_i) ce_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      en <= 1'b0;
      adj <= 5'h02;
      sah <= 6'($urandom);
      sal <= 8'($urandom);
      wid <= 4'($urandom_range(3, 1));
      repeat (3) @(posedge clk_i);
      en <= 1'b1;
      repeat (60) @(posedge clk_i);
    end
    tally_and_finish;
  end
endmodule : testbench
